// [logic/flash_cmd_pkg.sv]
// Constants for the serial flash command block: opcodes, address fields, timing.
// Assumes a 100 MHz system clock that oversamples the serial link.
package flash_cmd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Opcodes
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_PAUSE = 8'h75;
  localparam logic [7:0] OP_CONTINUE = 8'h7a;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QPAGE_PROG = 8'h32;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'hc7;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'h60;
  // Secure register address fields
  localparam logic [7:0] SEC_HI_BYTE = 8'h00;
  localparam logic [1:0] SEC_MID_BITS = 2'b00;
  localparam logic [9:0] SEC_OFS_LAST = 10'h3ff;
  localparam logic [9:0] SEC_OFS_FIRST = 10'h000;
  localparam int unsigned SEC_WORDS = 3 * 1024;
  // Continuous read mode subfield value that blocks reset
  localparam logic [1:0] CRM_DTR_LOCK = 2'b10;
  // Bit counts of a framed command
  localparam logic [5:0] BITS_OPCODE = 6'd8;
  localparam logic [5:0] BITS_ADDR_DUMMY = 6'd40;
  localparam logic [5:0] BITS_ID_DUMMY = 6'd32;
  // Timing, in ns, with derived cycle counts (least times round up)
  localparam int unsigned T_RESUME_NS = 200;
  localparam int unsigned T_RESUME_CYC = (T_RESUME_NS * CLK_MHZ) / 1000;
  localparam int unsigned T_RST_NS = 30000;
  localparam int unsigned T_DP_NS = 3000;
  localparam int unsigned T_RES_NS = 20000;
  localparam int unsigned T_SUS_NS = 20000;
  localparam int unsigned T_RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_DP_CYC = (T_DP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_RES_CYC = (T_RES_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_SUS_CYC = (T_SUS_NS * CLK_MHZ) / 1000;
  // Reset value of the suspend flags
  localparam logic [1:0] SUSPEND_RESET = 2'b00;
endpackage : flash_cmd_pkg

// [logic/delay_timer.sv]
// One-shot countdown timer: busy for the loaded number of cycles.
// Assumes a load pulse on the same clock; a new load restarts the count.
`timescale 1ns/10ps
module delay_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic load_i,
  input wire logic [15:0] count_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_q <= count_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && (cnt_q <= 16'h0001);
      busy_o <= busy_o && (cnt_q > 16'h0001);
      if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule : delay_timer

// [logic/flash_power_suspend_reset_cmds.sv]
// Serial flash command logic: secure reads, software reset, suspend/resume,
// deep sleep and wake/identify. Link pins are oversampled by clk_i; the
// array engine outside reports busy and completion through plain ports.
`timescale 1ns/10ps

// Functional notes
// - Secure read 48H takes three address bytes and a dummy, sampled on rising sclk.
// - After dummy, secure data shifts out on falling sclk from any start byte.
// - Address increments per byte; low ten bits wrap 3FFH to 000H until deselect.
// - Accepted reset aborts operations and clears all volatile state to defaults.
// - Reset needs 66H then 99H in separate selects, single or quad mode.
// - During reset recovery every command is refused.
// - Reset opcodes are ignored in quad double-rate continuous read mode.
// - Suspend 75H accepted only with program/erase running and not suspended.
// - Suspend sets flags at once, clears busy within suspend latency.
// - Program suspend rejects status write, secure erase/program, erases and page programs.
// - Erase suspend rejects status write, secure erase and erase opcodes.
// - Resume 7AH needs suspended and idle; clears flags, busy within 200ns.
// - Deep sleep B9H runs only if select rises after eighth bit.
// - In deep sleep only wake/identify and software reset are heard.
// - Deep sleep is rejected while an internal cycle runs.
// - Deselect with no cycle pending enters standby, also after power-up.
// - Wake ABH alone then deselect; commands refused until wake delay ends.
// - ABH plus three dummies streams the device code MSB first, repeatedly.
// - Wake/identify is ignored while busy.
// - Mode switching keeps write enable latch, suspend state and wrap bits.
module flash_power_suspend_reset_cmds #(
  parameter logic [7:0] DEVICE_CODE = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // Mode and volatile settings
  input wire logic quad_command_mode_i,
  input wire logic [1:0] cont_read_mode_subfield_i,
  input wire logic wel_set_i,
  input wire logic [7:0] read_param_set_i,
  input wire logic [2:0] wrap_set_i,
  input wire logic settings_load_i,
  // Internal array engine
  input wire logic pgm_busy_i,
  input wire logic erase_busy_i,
  input wire logic op_done_i,
  input wire logic sec_wr_i,
  input wire logic [11:0] sec_wr_addr_i,
  input wire logic [7:0] sec_wr_data_i,
  // Status and control out
  output logic write_in_progress_o,
  output logic [1:0] suspend_flags_o,
  output logic write_enable_latch_o,
  output logic [7:0] read_param_bits_o,
  output logic [7:0] cont_read_mode_bits_o,
  output logic [2:0] wrap_bits_o,
  output logic deep_sleep_o,
  output logic standby_o,
  output logic abort_o,
  output logic cmd_rejected_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [1:0] cs_s_q, sclk_s_q, si_s_q;
  logic cs_d1_q, sclk_d1_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_s_q <= 2'b11;
      sclk_s_q <= 2'b00;
      si_s_q <= 2'b00;
      cs_d1_q <= 1'b1;
      sclk_d1_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[0], cs_n_i};
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      si_s_q <= {si_s_q[0], si_i};
      cs_d1_q <= cs_s_q[1];
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  wire cs_low = !cs_s_q[1];
  wire cs_fall = cs_d1_q && !cs_s_q[1];
  wire cs_rise = !cs_d1_q && cs_s_q[1];
  wire sclk_rise = cs_low && !sclk_d1_q && sclk_s_q[1];
  wire sclk_fall = cs_low && sclk_d1_q && !sclk_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Secure register storage, three pages of 1 KiB
  logic [7:0] sec_mem [0:flash_cmd_pkg::SEC_WORDS-1];

  function automatic logic [11:0] sec_index(input logic [23:0] a);
    logic [1:0] sel;
    sel = a[13:12] - 2'd1;
    sec_index = {sel, a[9:0]};
  endfunction : sec_index

  function automatic logic is_sec_addr(input logic [23:0] a);
    is_sec_addr = (a[23:16] == flash_cmd_pkg::SEC_HI_BYTE) && (a[15:14] == 2'b00)
      && (a[13:12] != 2'b00) && (a[11:10] == flash_cmd_pkg::SEC_MID_BITS);
  endfunction : is_sec_addr

  always_ff @(posedge clk_i) begin
    if (sec_wr_i && (sec_wr_addr_i < 12'(flash_cmd_pkg::SEC_WORDS))) begin
      sec_mem[sec_wr_addr_i] <= sec_wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command framing
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_SEC_OUT, ST_ID_DUMMY, ST_ID_OUT, ST_IGNORE
  } frame_t;

  frame_t frame_q, frame_d;
  logic [5:0] bits_q;
  logic [7:0] op_q;
  logic [31:0] shift_q;
  logic [23:0] addr_q;
  logic [7:0] out_q;
  logic [2:0] out_bit_q;
  logic sec_valid_q;
  logic rst_armed_q;
  logic [1:0] suspend_q;
  logic wip_q, wel_q, dp_q, standby_q, abort_q, rej_q;
  logic [7:0] rparam_q, crm_q;
  logic [2:0] wrap_q;
  logic so_q, so_oe_n_q;

  wire [7:0] op_now = {shift_q[6:0], si_s_q[1]};
  wire op_complete = sclk_rise && (frame_q == ST_OPCODE) && (bits_q == 6'd7);

  // Timers share one counter; reset, sleep and wake phases block commands while running
  logic tmr_load;
  logic [15:0] tmr_count;
  logic tmr_busy, tmr_done;
  typedef enum logic [2:0] {PH_NONE, PH_RESET, PH_DP, PH_WAKE, PH_RESUME, PH_SUS} phase_t;
  phase_t phase_q;

  delay_timer u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  wire blocking = tmr_busy && (phase_q == PH_RESET || phase_q == PH_WAKE
    || phase_q == PH_DP);
  wire running = pgm_busy_i || erase_busy_i;
  wire susp_any = suspend_q != 2'b00;
  wire dtr_locked = cont_read_mode_subfield_i == flash_cmd_pkg::CRM_DTR_LOCK;

  // Opcodes refused under suspend
  wire erase_op = (op_now == flash_cmd_pkg::OP_ERASE_4K) || (op_now == flash_cmd_pkg::OP_ERASE_32K)
    || (op_now == flash_cmd_pkg::OP_ERASE_64K) || (op_now == flash_cmd_pkg::OP_ERASE_CHIP_A)
    || (op_now == flash_cmd_pkg::OP_ERASE_CHIP_B);
  wire erase_susp_bad = (op_now == flash_cmd_pkg::OP_WR_STATUS)
    || (op_now == flash_cmd_pkg::OP_SEC_ERASE) || erase_op;
  wire pgm_susp_bad = erase_susp_bad || (op_now == flash_cmd_pkg::OP_SEC_PROG)
    || (op_now == flash_cmd_pkg::OP_PAGE_PROG) || (op_now == flash_cmd_pkg::OP_QPAGE_PROG);
  wire susp_reject = (suspend_q[0] && pgm_susp_bad) || (suspend_q[1] && erase_susp_bad);
  wire sleep_reject = dp_q && (op_now != flash_cmd_pkg::OP_WAKE_ID)
    && (op_now != flash_cmd_pkg::OP_RST_EN) && (op_now != flash_cmd_pkg::OP_RST);
  wire op_refused = blocking || susp_reject || sleep_reject;

  // Commands executed at deselect; all but wake need exactly eight bits seen
  wire exact_op = cs_rise && (frame_q == ST_IGNORE) && (bits_q == flash_cmd_pkg::BITS_OPCODE);
  wire do_rst_en = exact_op && (op_q == flash_cmd_pkg::OP_RST_EN) && !dtr_locked;
  wire do_reset = exact_op && (op_q == flash_cmd_pkg::OP_RST) && rst_armed_q && !dtr_locked;
  wire do_pause = exact_op && (op_q == flash_cmd_pkg::OP_PAUSE) && running
    && !susp_any && wip_q;
  wire do_continue = exact_op && (op_q == flash_cmd_pkg::OP_CONTINUE) && susp_any
    && !wip_q;
  wire do_sleep = exact_op && (op_q == flash_cmd_pkg::OP_DEEP_SLEEP) && !wip_q
    && !running;
  wire do_wake = cs_rise && (op_q == flash_cmd_pkg::OP_WAKE_ID) && dp_q
    && (frame_q == ST_IGNORE || frame_q == ST_ID_DUMMY || frame_q == ST_ID_OUT)
    && !wip_q;

  always_comb begin
    frame_d = frame_q;
    if (cs_fall || !cs_low) begin
      frame_d = ST_OPCODE;
    end else if (op_complete) begin
      frame_d = ST_IGNORE;
      if (!op_refused) begin
        if (op_now == flash_cmd_pkg::OP_SEC_READ && !dp_q) begin
          frame_d = ST_ADDR;
        end else if (op_now == flash_cmd_pkg::OP_WAKE_ID && !wip_q) begin
          frame_d = ST_ID_DUMMY;
        end
      end
    end else if (sclk_rise && frame_q == ST_ADDR && bits_q == 6'(flash_cmd_pkg::BITS_ADDR_DUMMY - 1)) begin
      frame_d = ST_SEC_OUT;
    end else if (sclk_rise && frame_q == ST_ID_DUMMY && bits_q == 6'(flash_cmd_pkg::BITS_ID_DUMMY - 1)) begin
      frame_d = ST_ID_OUT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cs_low) begin
      frame_q <= ST_OPCODE;
    end else begin
      frame_q <= frame_d;
    end
  end

  // Bit counter, opcode and address capture
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cs_fall) begin
      bits_q <= 6'd0;
      shift_q <= 32'h0;
      if (sys_rst_i) begin
        op_q <= 8'h00;
      end
    end else if (sclk_rise) begin
      shift_q <= {shift_q[30:0], si_s_q[1]};
      if (bits_q != 6'h3f) begin
        bits_q <= bits_q + 6'd1;
      end
      if (op_complete) begin
        op_q <= op_refused ? 8'h00 : op_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data out: secure bytes and repeating device code
  wire addr_done = sclk_rise && frame_q == ST_ADDR && bits_q == 6'd31;
  wire sec_start = sclk_rise && frame_q == ST_ADDR
    && bits_q == 6'(flash_cmd_pkg::BITS_ADDR_DUMMY - 1);
  wire id_start = sclk_rise && frame_q == ST_ID_DUMMY
    && bits_q == 6'(flash_cmd_pkg::BITS_ID_DUMMY - 1);
  wire [7:0] sec_byte = sec_valid_q ? sec_mem[sec_index(addr_q)] : 8'hff;
  wire [9:0] next_ofs = (addr_q[9:0] == flash_cmd_pkg::SEC_OFS_LAST)
    ? flash_cmd_pkg::SEC_OFS_FIRST : addr_q[9:0] + 10'd1;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cs_low) begin
      addr_q <= 24'h0;
      sec_valid_q <= 1'b0;
      out_q <= 8'h00;
      out_bit_q <= 3'd0;
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      if (addr_done) begin
        addr_q <= {shift_q[22:0], si_s_q[1]};
        sec_valid_q <= is_sec_addr({shift_q[22:0], si_s_q[1]});
      end
      if (sec_start) begin
        out_q <= sec_byte;
        out_bit_q <= 3'd7;
        addr_q[9:0] <= next_ofs;
      end else if (id_start) begin
        out_q <= DEVICE_CODE;
        out_bit_q <= 3'd7;
      end else if (sclk_fall && (frame_q == ST_SEC_OUT || frame_q == ST_ID_OUT)) begin
        so_q <= out_q[out_bit_q];
        so_oe_n_q <= 1'b0;
        out_bit_q <= out_bit_q - 3'd1;
        if (out_bit_q == 3'd0) begin
          out_q <= frame_q == ST_SEC_OUT ? sec_byte : DEVICE_CODE;
          if (frame_q == ST_SEC_OUT) begin
            addr_q[9:0] <= next_ofs;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power, suspend, reset state
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 16'h0;
    if (do_reset) begin
      tmr_load = 1'b1;
      tmr_count = 16'(flash_cmd_pkg::T_RST_CYC);
    end else if (do_wake) begin
      tmr_load = 1'b1;
      tmr_count = 16'(flash_cmd_pkg::T_RES_CYC);
    end else if (do_sleep) begin
      tmr_load = 1'b1;
      tmr_count = 16'(flash_cmd_pkg::T_DP_CYC);
    end else if (do_pause) begin
      tmr_load = 1'b1;
      tmr_count = 16'(flash_cmd_pkg::T_SUS_CYC);
    end else if (do_continue) begin
      tmr_load = 1'b1;
      tmr_count = 16'(flash_cmd_pkg::T_RESUME_CYC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_q <= PH_NONE;
      rst_armed_q <= 1'b0;
      suspend_q <= flash_cmd_pkg::SUSPEND_RESET;
      wip_q <= 1'b0;
      wel_q <= 1'b0;
      dp_q <= 1'b0;
      standby_q <= 1'b1;
      rparam_q <= 8'h00;
      crm_q <= 8'h00;
      wrap_q <= 3'h0;
      abort_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      abort_q <= do_reset;
      rej_q <= op_complete && op_refused;
      if (cs_fall) begin
        standby_q <= 1'b0;
      end else if (cs_rise && !running && !wip_q) begin
        standby_q <= 1'b1;
      end
      if (exact_op) begin
        rst_armed_q <= do_rst_en;
      end
      if (settings_load_i) begin
        // Mode switches do not touch these; only this load and reset do
        wel_q <= wel_set_i;
        rparam_q <= read_param_set_i;
        wrap_q <= wrap_set_i;
        crm_q <= {2'b00, cont_read_mode_subfield_i, 4'h0};
      end
      if (tmr_load) begin
        phase_q <= do_reset ? PH_RESET : do_wake ? PH_WAKE : do_sleep ? PH_DP
          : do_pause ? PH_SUS : PH_RESUME;
      end else if (tmr_done) begin
        phase_q <= PH_NONE;
      end
      if (do_reset) begin
        suspend_q <= flash_cmd_pkg::SUSPEND_RESET;
        wip_q <= 1'b0;
        wel_q <= 1'b0;
        dp_q <= 1'b0;
        rparam_q <= 8'h00;
        crm_q <= 8'h00;
        wrap_q <= 3'h0;
        rst_armed_q <= 1'b0;
      end else begin
        if (do_pause) begin
          suspend_q <= {erase_busy_i, pgm_busy_i};
        end else if (do_continue) begin
          suspend_q <= 2'b00;
        end
        if (tmr_done && phase_q == PH_SUS) begin
          wip_q <= 1'b0;
        end else if (tmr_done && phase_q == PH_RESUME) begin
          wip_q <= 1'b1;
        end else if (running && !susp_any && phase_q != PH_SUS) begin
          wip_q <= 1'b1;
        end else if (op_done_i) begin
          wip_q <= 1'b0;
        end
        if (tmr_done && phase_q == PH_DP) begin
          dp_q <= 1'b1;
        end else if (do_wake) begin
          dp_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      so_o <= 1'b0;
      so_oe_n_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      so_o <= so_q;
      so_oe_n_o <= so_oe_n_q;
      busy_o <= blocking;
    end
  end

  always_ff @(posedge clk_i) begin
    write_in_progress_o <= wip_q;
    suspend_flags_o <= suspend_q;
    write_enable_latch_o <= wel_q;
    read_param_bits_o <= rparam_q;
    cont_read_mode_bits_o <= crm_q;
    wrap_bits_o <= wrap_q;
    deep_sleep_o <= dp_q;
    standby_o <= standby_q;
    abort_o <= abort_q;
    cmd_rejected_o <= rej_q;
  end

endmodule : flash_power_suspend_reset_cmds

// [testbench/flash_cmds_checker.sv]
// Assertions on the flash command block: reset, suspend, sleep, wake.
// Sees only the block's ports; bound below the module.
`timescale 1ns/10ps
module flash_cmds_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic cs_n_i,
  input wire logic so_oe_n_o,
  input wire logic write_in_progress_o,
  input wire logic [1:0] suspend_flags_o,
  input wire logic write_enable_latch_o,
  input wire logic [2:0] wrap_bits_o,
  input wire logic deep_sleep_o,
  input wire logic abort_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [11:0] sus_cnt_q;
  logic [11:0] sus_cnt_d;
  // Suspend latency is too long for a delay range
  assign sus_cnt_d = (|suspend_flags_o && write_in_progress_o) ? sus_cnt_q + 12'h001 : 12'h000;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sus_cnt_q <= 12'h000;
    end else begin
      sus_cnt_q <= sus_cnt_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_abort_clears_state: assert property (abort_o |-> ##[0:2] (suspend_flags_o == 2'b00 &&
    !write_enable_latch_o && !deep_sleep_o && wrap_bits_o == 3'h0))
    else $error("abort left volatile state set");
  a_abort_single_pulse: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  a_reset_recovery_busy: assert property (abort_o |-> ##[0:2] busy_o)
    else $error("no recovery interval after reset");
  a_busy_no_suspend: assert property (busy_o |-> !$rose(|suspend_flags_o))
    else $error("suspend accepted during recovery");
  a_suspend_needs_wip: assert property ($rose(|suspend_flags_o) |-> $past(write_in_progress_o))
    else $error("suspend accepted while idle");
  a_suspend_latency: assert property (sus_cnt_q <= flash_cmd_pkg::T_SUS_CYC + 4)
    else $error("busy flag not cleared after suspend");
  a_resume_sets_wip: assert property (($fell(|suspend_flags_o) && !abort_o && !$past(abort_o))
    |-> ##[0:25] write_in_progress_o)
    else $error("resume did not restart the cycle");
  a_sleep_not_busy: assert property ($rose(deep_sleep_o) |-> !write_in_progress_o)
    else $error("deep sleep entered during a cycle");
  a_wake_delay_busy: assert property ($fell(deep_sleep_o) |-> ##[0:2] busy_o)
    else $error("no wake delay after leaving sleep");
  a_oe_idle_deselect: assert property (cs_n_i [*6] |-> so_oe_n_o)
    else $error("output driven while deselected");
endmodule : flash_cmds_checker

bind flash_power_suspend_reset_cmds flash_cmds_checker u_chk (.clk_i, .sys_rst_i, .cs_n_i,
  .so_oe_n_o, .write_in_progress_o, .suspend_flags_o, .write_enable_latch_o, .wrap_bits_o,
  .deep_sleep_o, .abort_o, .busy_o);

// [testbench/flash_host_model.sv]
// Host side of the serial link: frames commands, clocks out reply bytes.
// Link clock is 160 ns, stepped on falling edges of the system clock.
`timescale 1ns/10ps
module flash_host_model (
  // Clock
  input wire logic clk_i,
  // Link
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i
);
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  event rx_ev;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk_i);
  endtask : half
  // One select period per call; clock stands low outside it
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = ntx - 1; i >= 0; i--) begin
      si_o = tx[i];
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
    for (int i = 0; i < nrx * 8; i++) begin
      si_o = ~si_o;
      half();
      rx_sh = {rx_sh[6:0], so_i};
      sclk_o = 1'b1;
      if (i % 8 == 7) begin
        rx_byte = rx_sh;
        ->rx_ev;
      end
      half();
      sclk_o = 1'b0;
    end
    si_o = ~si_o;
    half();
    cs_n_o = 1'b1;
    repeat (24) @(negedge clk_i);
  endtask : frame
endmodule : flash_host_model

// [testbench/flash_power_suspend_reset_cmds_tb.sv]
// Self-checking bench for the flash command block.
// Host model drives the link; engine and settings ports driven here.
`timescale 1ns/10ps
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g))
module flash_power_suspend_reset_cmds_tb;
  typedef struct {string nm; logic [7:0] v;} note_t;
  logic clk_i = 0, sys_rst_i = 1, cs_n_i, sclk_i, si_i, so_o, so_oe_n_o;
  logic quad_command_mode_i = 0, wel_set_i = 0, settings_load_i = 0;
  logic [1:0] cont_read_mode_subfield_i = 2'h0;
  logic [7:0] read_param_set_i = 8'h00, sec_wr_data_i = 8'h00, rp, d;
  logic [2:0] wrap_set_i = 3'h0, wr;
  logic pgm_busy_i = 0, erase_busy_i = 0, op_done_i = 0, sec_wr_i = 0;
  logic [11:0] sec_wr_addr_i = 12'h000;
  logic write_in_progress_o, write_enable_latch_o, deep_sleep_o, standby_o;
  logic abort_o, cmd_rejected_o, busy_o;
  logic [1:0] suspend_flags_o;
  logic [7:0] read_param_bits_o, cont_read_mode_bits_o;
  logic [2:0] wrap_bits_o;
  logic [31:0] seed = 32'h0000003d;
  int n_errors = 0, total_checks = 0, cyc = 0, n_rej = 0, n_abort = 0, mark = 0;
  note_t exp_q[$];
  note_t nt;
  logic [7:0] bad_ops[10] = '{8'h01, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
    8'h02, 8'h32};
  logic [11:0] sec_at[3] = '{12'h7fe, 12'h7ff, 12'h400};
  initial forever #5 clk_i = ~clk_i;
  flash_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i),
    .so_i(so_o));
  flash_power_suspend_reset_cmds #(.DEVICE_CODE(8'h3c)) uut (.clk_i, .sys_rst_i, .cs_n_i,
    .sclk_i, .si_i, .so_o, .so_oe_n_o, .quad_command_mode_i, .cont_read_mode_subfield_i,
    .wel_set_i, .read_param_set_i, .wrap_set_i, .settings_load_i, .pgm_busy_i,
    .erase_busy_i, .op_done_i, .sec_wr_i, .sec_wr_addr_i, .sec_wr_data_i,
    .write_in_progress_o, .suspend_flags_o, .write_enable_latch_o, .read_param_bits_o,
    .cont_read_mode_bits_o, .wrap_bits_o, .deep_sleep_o, .standby_o, .abort_o,
    .cmd_rejected_o, .busy_o);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic op(input logic [7:0] c);
    u_host.frame({56'h0, c}, 8, 0);
    repeat (8) @(negedge clk_i);
  endtask : op
  task automatic wait_low(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b0; n++) @(negedge clk_i);
  endtask : wait_low
  always @(posedge clk_i) begin
    // Pulse counts; scenarios compare them before and after a command
    n_rej <= n_rej + ((cmd_rejected_o === 1'b1) ? 1 : 0);
    n_abort <= n_abort + ((abort_o === 1'b1) ? 1 : 0);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Reply bytes are matched in order against the driver's notes
  initial forever begin
    @(u_host.rx_ev);
    nt = exp_q.pop_front();
    `CHK(nt.nm, nt.v, u_host.rx_byte);
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (4) @(negedge clk_i);
    `CHK("standby", 1, standby_o);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      sec_wr_i = 1;
      sec_wr_addr_i = sec_at[i];
      sec_wr_data_i = d;
      exp_q.push_back('{"sec_byte", d});
      @(negedge clk_i);
    end
    sec_wr_i = 0;
    u_host.frame(64'h48_0023fe_00, 40, 3);
    exp_q.push_back('{"sec_ofs0", d});
    u_host.frame(64'h48_002000_00, 40, 1);
    exp_q.push_back('{"dev_code", 8'h3c});
    exp_q.push_back('{"dev_code", 8'h3c});
    u_host.frame(64'hab_000000, 32, 2);
    rp = rnd();
    wr = 3'(rnd());
    {wel_set_i, read_param_set_i, wrap_set_i, settings_load_i} = {1'b1, rp, wr, 1'b1};
    cont_read_mode_subfield_i = 2'b01;
    @(negedge clk_i);
    settings_load_i = 0;
    quad_command_mode_i = 1;
    repeat (4) @(negedge clk_i);
    `CHK("wel", 1, write_enable_latch_o);
    `CHK("wrap", wr, wrap_bits_o);
    `CHK("rparam", rp, read_param_bits_o);
    `CHK("crm", 8'h10, cont_read_mode_bits_o);
    quad_command_mode_i = 0;
    pgm_busy_i = 1;
    repeat (4) @(negedge clk_i);
    op(8'h75);
    `CHK("sus_set", 2'b01, suspend_flags_o);
    wait_low(write_in_progress_o, 2100);
    `CHK("sus_wip", 0, write_in_progress_o);
    foreach (bad_ops[i]) begin
      mark = n_rej;
      op(bad_ops[i]);
      `CHK("refused", 1, n_rej - mark);
    end
    op(8'h7a);
    `CHK("resumed", 0, suspend_flags_o);
    op(8'hb9);
    repeat (400) @(negedge clk_i);
    `CHK("sleep_busy", 0, deep_sleep_o);
    {pgm_busy_i, op_done_i} = 2'b01;
    @(negedge clk_i);
    op_done_i = 0;
    repeat (4) @(negedge clk_i);
    `CHK("done_wip", 0, write_in_progress_o);
    u_host.frame(64'h5c, 7, 0);
    u_host.frame(64'h172, 9, 0);
    repeat (400) @(negedge clk_i);
    `CHK("sleep_frame", 0, deep_sleep_o);
    op(8'hb9);
    repeat (320) @(negedge clk_i);
    `CHK("sleep", 1, deep_sleep_o);
    op(8'hab);
    `CHK("woken", 0, deep_sleep_o);
    `CHK("wake_busy", 1, busy_o);
    wait_low(busy_o, 2100);
    `CHK("pre_rst_wip", 0, write_in_progress_o);
    `CHK("pre_rst_sus", 0, suspend_flags_o);
    cont_read_mode_subfield_i = 2'b10;
    mark = n_abort;
    op(8'h66);
    op(8'h99);
    `CHK("rst_locked", 0, n_abort - mark);
    cont_read_mode_subfield_i = 2'b00;
    quad_command_mode_i = 1;
    mark = n_abort;
    op(8'h66);
    op(8'h99);
    `CHK("rst_done", 1, n_abort - mark);
    `CHK("rst_wel", 0, write_enable_latch_o);
    `CHK("rst_rparam", 0, read_param_bits_o);
    `CHK("rst_wrap", 0, wrap_bits_o);
    `CHK("rst_crm", 0, cont_read_mode_bits_o);
    op(8'hb9);
    repeat (350) @(negedge clk_i);
    `CHK("rst_refuse", 0, deep_sleep_o);
    `CHK("notes_left", 0, exp_q.size());
    tally_and_finish();
  end
endmodule : flash_power_suspend_reset_cmds_tb
